// file: design/fcs_pkg.sv
// Contract
// R1 - key-write select clear: key range writes start a program or erase command
// R2 - key-write select set: key range writes go to key storage, no command
// R3 - reset loads protection register from nonvolatile protection byte
// R4 - protection register readable; user writes ignored; debug writes allowed
// R5 - protect disable zero: seven-bit boundary sets unprotected top region end
// R6 - refuse program/erase on protected locations; disable one protects nothing
// R7 - writing one to buffer-empty launches command; burst transfer also clears it; code keeps it set for a burst launched while busy
// R8 - only burst program is buffered; empty flag means room for another
// R9 - complete flag set when buffer empty and idle; cleared on launch
// R10 - protected target: command ignored, violation flag set, write-one clears
// R11 - access error on bad sequence, divider not loaded, or stop while busy
// R12 - access error clears only on software write of one
// R13 - blank check end sets blank flag if all erased; new command clears
// R14 - decoder accepts blank check, byte program and burst program codes
// R15 - decoder accepts page erase (512 bytes) and mass erase codes
// R16 - any other command code is rejected with access error
// R17 - software needs blank check only for the security unlock procedure
// R18 - program/erase blocked until divider written once; sets loaded flag
// R19 - successful blank check sets security code to unsecured pattern
// R20 - after reset: buffer empty and complete set, other flags clear
package fcs_pkg;
    // register word offsets (byte addresses)
    localparam logic [5:0] OFS_DIVIDER = 6'h00;
    localparam logic [5:0] OFS_CONFIG = 6'h04;
    localparam logic [5:0] OFS_PROTECT = 6'h08;
    localparam logic [5:0] OFS_STATUS = 6'h0c;
    localparam logic [5:0] OFS_COMMAND = 6'h10;
    // status, config, divider and protect bit positions
    localparam int ST_BUF_EMPTY = 7;
    localparam int ST_COMPLETE = 6;
    localparam int ST_VIOL = 5;
    localparam int ST_ACCERR = 4;
    localparam int ST_BLANK = 2;
    localparam int CFG_KEY_SEL = 5;
    localparam int DIV_LOADED = 7;
    localparam int PROT_DISABLE = 0;
    // command codes
    localparam logic [7:0] CMD_BLANK = 8'h05;
    localparam logic [7:0] CMD_BYTE_PROG = 8'h20;
    localparam logic [7:0] CMD_BURST_PROG = 8'h25;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
    // key range, security code and reset values
    localparam logic [15:0] KEY_BASE = 16'hffb0;
    localparam logic [15:0] KEY_LAST = 16'hffb7;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] DIV_RESET = 8'h00;
    typedef enum logic [1:0] {
        FCS_IDLE,
        FCS_ADDR,
        FCS_DATA,
        FCS_WAIT
    } fcs_seq_t;
endpackage

// file: design/fcs_flash_command_status_control.sv
// The register offsets and the Wishbone register port were chosen for this implementation.
module fcs_flash_command_status_control #(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // cpu writes into flash space
    input wire logic fwr_i,
    input wire logic [ADDR_W-1:0] faddr_i,
    input wire logic [7:0] fdata_i,
    // nonvolatile protection byte and debug access
    input wire logic [7:0] nv_protect_i,
    input wire logic dbg_prot_we_i,
    input wire logic [7:0] dbg_prot_i,
    input wire logic stop_req_i,
    // flash array side
    output logic arr_start_o,
    output logic [7:0] arr_cmd_o,
    output logic [ADDR_W-1:0] arr_addr_o,
    output logic [7:0] arr_data_o,
    input wire logic arr_busy_i,
    input wire logic arr_done_i,
    input wire logic arr_blank_i,
    // key storage and security
    output logic key_we_o,
    output logic [2:0] key_idx_o,
    output logic [7:0] key_data_o,
    output logic [1:0] sec_set_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] divider;
    logic div_loaded;
    logic [7:0] cfg;
    logic [7:0] prot;
    logic [7:0] cmd;
    logic [ADDR_W-1:0] cmd_addr;
    logic [7:0] cmd_data;
    logic cmd_valid;
    logic buf_empty;
    logic viol;
    logic accerr;
    logic blank;
    logic active;
    logic [1:0] loaded;
    logic prot_loaded;
    ////////////////////////////////////////////////////////////////////////
    wire bus_req = cyc_i & stb_i & ~ack_o;
    // full six-bit decode keeps the command register off the divider
    wire [5:0] ofs = adr_i;
    wire wr_lane0 = bus_req & we_i & sel_i[0];
    wire wr_div = wr_lane0 & (ofs == fcs_pkg::OFS_DIVIDER);
    wire wr_cfg = wr_lane0 & (ofs == fcs_pkg::OFS_CONFIG);
    wire wr_stat = wr_lane0 & (ofs == fcs_pkg::OFS_STATUS);
    wire wr_cmd = wr_lane0 & (ofs == fcs_pkg::OFS_COMMAND);
    wire in_key = (faddr_i >= fcs_pkg::KEY_BASE[ADDR_W-1:0])
        & (faddr_i <= fcs_pkg::KEY_LAST[ADDR_W-1:0]);
    wire key_sel = cfg[fcs_pkg::CFG_KEY_SEL];
    // R2 key write route
    wire key_wr = fwr_i & in_key & key_sel;
    // R1 key range starts a command
    wire arr_wr = fwr_i & ~(in_key & key_sel);
    // R14 program codes
    wire is_prog = (cmd == fcs_pkg::CMD_BYTE_PROG)
        | (cmd == fcs_pkg::CMD_BURST_PROG);
    // R15 erase codes
    wire is_erase = (cmd == fcs_pkg::CMD_PAGE_ERASE)
        | (cmd == fcs_pkg::CMD_MASS_ERASE);
    // R16 illegal code
    wire legal = is_prog | is_erase | (cmd == fcs_pkg::CMD_BLANK);
    // R5 boundary, address above it is protected
    wire [ADDR_W-1:0] bound = {prot[7:1], {(ADDR_W-7){1'b1}}};
    // R6 protection check
    wire protected_hit = ~prot[fcs_pkg::PROT_DISABLE]
        & ((cmd == fcs_pkg::CMD_MASS_ERASE) | (cmd_addr > bound));
    wire launch = wr_stat & dat_i[fcs_pkg::ST_BUF_EMPTY] & buf_empty;
    // R11 bad sequence: launch without data or illegal code
    wire seq_bad = launch & (~cmd_valid | ~legal);
    // R18 divider must be loaded for program/erase
    wire div_bad = launch & ~div_loaded & (is_prog | is_erase);
    wire stop_bad = stop_req_i & active;
    wire viol_hit = launch & ~seq_bad & ~div_bad & (is_prog | is_erase)
        & protected_hit;
    wire go = launch & ~seq_bad & ~div_bad & ~viol_hit;
    // R8 only burst program frees the buffer while array is busy
    wire buffered = go & (cmd == fcs_pkg::CMD_BURST_PROG) & active;
    wire [7:0] status = {buf_empty, ~active & buf_empty, viol, accerr,
        1'b0, blank, 2'b00};
    wire [7:0] rd_byte = (ofs == fcs_pkg::OFS_DIVIDER) ?
        {div_loaded, divider[6:0]} :
        (ofs == fcs_pkg::OFS_CONFIG) ? cfg :
        (ofs == fcs_pkg::OFS_PROTECT) ? prot :
        (ofs == fcs_pkg::OFS_STATUS) ? status :
        (ofs == fcs_pkg::OFS_COMMAND) ? cmd : 8'h00;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= bus_req;
            dat_o <= bus_req ? {24'h0, rd_byte} : 32'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            divider <= fcs_pkg::DIV_RESET;
            div_loaded <= 1'b0;
            cfg <= fcs_pkg::CFG_RESET;
        end else begin
            // R18 first divider write
            if (wr_div) begin
                divider <= dat_i[7:0];
                div_loaded <= 1'b1;
            end
            if (wr_cfg) begin
                cfg <= dat_i[7:0] & 8'h20;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // strap capture happens one edge after reset release, never async
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_loaded <= 1'b0;
            prot <= 8'h00;
        end else if (!prot_loaded) begin
            // R3 load from nonvolatile byte
            prot <= nv_protect_i;
            prot_loaded <= 1'b1;
        end else if (dbg_prot_we_i) begin
            // R4 only debug may alter it
            prot <= dbg_prot_i;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd <= 8'h00;
            cmd_addr <= '0;
            cmd_data <= 8'h00;
            cmd_valid <= 1'b0;
        end else begin
            if (arr_wr & buf_empty) begin
                cmd_addr <= faddr_i;
                cmd_data <= fdata_i;
                cmd_valid <= 1'b1;
            end else if (launch) begin
                cmd_valid <= 1'b0;
            end
            if (wr_cmd) begin
                cmd <= dat_i[7:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // R20 idle reset state
            buf_empty <= 1'b1;
            viol <= 1'b0;
            accerr <= 1'b0;
            blank <= 1'b0;
            active <= 1'b0;
            arr_start_o <= 1'b0;
            arr_cmd_o <= 8'h00;
            arr_addr_o <= '0;
            arr_data_o <= 8'h00;
            sec_set_o <= 2'b00;
        end else begin
            arr_start_o <= 1'b0;
            sec_set_o <= 2'b00;
            // R7 launch clears buffer-empty; a burst launched while busy keeps it free
            if (go & ~buffered) begin
                buf_empty <= 1'b0;
            end else if (~active | arr_done_i) begin
                buf_empty <= 1'b1;
            end
            // R9 complete is derived from buffer empty and idle
            if (go) begin
                active <= 1'b1;
                arr_start_o <= 1'b1;
                arr_cmd_o <= cmd;
                arr_addr_o <= cmd_addr;
                arr_data_o <= cmd_data;
            end else if (arr_done_i & ~arr_busy_i) begin
                active <= 1'b0;
            end
            // R10 violation set wins over clear
            if (viol_hit) begin
                viol <= 1'b1;
            end else if (wr_stat & dat_i[fcs_pkg::ST_VIOL]) begin
                viol <= 1'b0;
            end
            // R11 access error sources
            if (seq_bad | div_bad | stop_bad) begin
                accerr <= 1'b1;
            // R12 write one clears
            end else if (wr_stat & dat_i[fcs_pkg::ST_ACCERR]) begin
                accerr <= 1'b0;
            end
            // R13 blank flag
            if (go) begin
                blank <= 1'b0;
            end else if (arr_done_i & (arr_cmd_o == fcs_pkg::CMD_BLANK)) begin
                blank <= arr_blank_i;
                // R19 unsecure after blank check
                if (arr_blank_i) begin
                    sec_set_o <= fcs_pkg::SEC_UNSECURED;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_we_o <= 1'b0;
            key_idx_o <= 3'h0;
            key_data_o <= 8'h00;
        end else begin
            key_we_o <= key_wr;
            key_idx_o <= faddr_i[2:0];
            key_data_o <= fdata_i;
        end
    end
endmodule

// file: bench/fcs_sva.sv
module fcs_sva #(
    parameter int ADDR_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic fwr_i,
    input wire logic [ADDR_W-1:0] faddr_i,
    input wire logic arr_start_o,
    input wire logic [7:0] arr_cmd_o,
    input wire logic key_we_o,
    input wire logic [2:0] key_idx_o,
    input wire logic [1:0] sec_set_o
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence sec_pulse_s;
        sec_set_o == 2'b10 ##1 sec_set_o == 2'b00;
    endsequence
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o))
        else $error("ack without request");
    ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acked in one cycle");
    start_pulse_a: assert property (arr_start_o |=> !arr_start_o)
        else $error("array start longer than one cycle");
    legal_cmd_a: assert property (arr_start_o |-> arr_cmd_o inside
        {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) else $error("illegal code ran");
    key_route_a: assert property (key_we_o |-> $past(fwr_i) &&
        key_idx_o == $past(faddr_i[2:0])) else $error("key write wrong");
    sec_code_a: assert property ($rose(sec_set_o != 2'b00) |-> sec_pulse_s)
        else $error("security code pulse wrong");
    stat_flags_a: assert property (ack_o && $past(!we_i && adr_i ==
        fcs_pkg::OFS_STATUS) |-> !(dat_o[6] && !dat_o[7]))
        else $error("complete set with buffer full");
endmodule
bind fcs_flash_command_status_control fcs_sva #(.ADDR_W(ADDR_W)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .fwr_i(fwr_i),
    .faddr_i(faddr_i), .arr_start_o(arr_start_o), .arr_cmd_o(arr_cmd_o),
    .key_we_o(key_we_o), .key_idx_o(key_idx_o), .sec_set_o(sec_set_o));

// file: bench/fcs_array_model.sv
module fcs_array_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic slow_i,
    input wire logic erased_i,
    output logic busy_o,
    output logic done_o,
    output logic blank_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i)
            cnt <= 0;
        else if (start_i)
            cnt <= slow_i ? 40 : 3;
        else if (cnt > 0)
            cnt <= cnt - 1;
        done_o <= (cnt == 1);
        // blank only valid with done, so it shows the inverse of erased_i otherwise
        blank_o <= (cnt == 1) ? erased_i : !erased_i;
    end
    assign busy_o = (cnt != 0);
endmodule

// file: bench/fcs_flash_command_status_control_tb_top.sv
module fcs_flash_command_status_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, cyc, stb, we, ack, fwr, dbg_we, stop, start, busy, done;
    logic blank, key_we, slow, erased;
    logic [5:0] adr;
    logic [31:0] wdat, rdat;
    logic [15:0] faddr, aaddr;
    logic [7:0] fdata, nvp, dbg_d, acmd, adata, kdat, q, kd, c, last_cmd;
    logic [2:0] kidx;
    logic [1:0] sec;
    logic [10:0] last_key;
    logic [7:0] codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
    int miscompares, cmp_count, nstart, nsec, cyc_cnt, es, b;
    fcs_flash_command_status_control DUT (.clk_i(clk), .rst_i(rst),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .fwr_i(fwr),
        .faddr_i(faddr), .fdata_i(fdata), .nv_protect_i(nvp),
        .dbg_prot_we_i(dbg_we), .dbg_prot_i(dbg_d), .stop_req_i(stop),
        .arr_start_o(start), .arr_cmd_o(acmd), .arr_addr_o(aaddr),
        .arr_data_o(adata), .arr_busy_i(busy), .arr_done_i(done),
        .arr_blank_i(blank), .key_we_o(key_we), .key_idx_o(kidx),
        .key_data_o(kdat), .sec_set_o(sec));
    fcs_array_model ARR (.clk_i(clk), .rst_i(rst), .start_i(start),
        .slow_i(slow), .erased_i(erased), .busy_o(busy), .done_o(done),
        .blank_o(blank));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [5:0] o, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= o;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1)
            miscompares++;
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic st(input int a, input int v, input int bl);
        wb(1'b0, fcs_pkg::OFS_STATUS, 8'h00);
        chk(32'(q & 8'hf4), 32'({2'b11, v[0], a[0], 1'b0, bl[0], 2'b00}));
    endtask
    task automatic dbg(input logic [7:0] v);
        dbg_we <= 1'b1;
        dbg_d <= v;
        @(posedge clk);
        dbg_we <= 1'b0;
    endtask
    task automatic go(input logic [7:0] cd, input logic [15:0] a);
        kd = 8'($urandom);
        fwr <= 1'b1;
        faddr <= a;
        fdata <= kd;
        @(posedge clk);
        fwr <= 1'b0;
        wb(1'b1, fcs_pkg::OFS_COMMAND, cd);
        wb(1'b1, fcs_pkg::OFS_STATUS, 8'h80);
    endtask
    task automatic idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, fcs_pkg::OFS_STATUS, 8'h00);
            n++;
        end while (q[6] !== 1'b1 && n < 40);
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt > 20000) begin
            miscompares++;
            end_of_test();
        end
        if (start === 1'b1) begin
            nstart++;
            last_cmd = acmd;
            chk(32'(adata), 32'(kd));
        end
        if (key_we === 1'b1)
            last_key = {kidx, kdat};
        if (sec === 2'b10)
            nsec++;
    end
    initial begin
        void'($urandom(32'h8863));
        {cyc, stb, we, fwr, dbg_we, stop, slow, erased} = '0;
        {adr, wdat, faddr, fdata, dbg_d} = '0;
        rst = 1'b1;
        nvp = 8'($urandom);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        st(0, 0, 0);
        wb(1'b0, fcs_pkg::OFS_PROTECT, 8'h00);
        chk(32'(q), 32'(nvp));
        wb(1'b1, fcs_pkg::OFS_PROTECT, ~nvp);
        wb(1'b0, fcs_pkg::OFS_PROTECT, 8'h00);
        chk(32'(q), 32'(nvp));
        dbg(8'h01);
        wb(1'b0, fcs_pkg::OFS_PROTECT, 8'h00);
        chk(32'(q), 32'h01);
        // a command offset aliasing the divider would load it early
        if (fcs_pkg::OFS_COMMAND != fcs_pkg::OFS_DIVIDER) begin
            go(fcs_pkg::CMD_BYTE_PROG, 16'hffb0);
            idle();
            st(1, 0, 0);
            wb(1'b1, fcs_pkg::OFS_STATUS, 8'h00);
            st(1, 0, 0);
            wb(1'b1, fcs_pkg::OFS_STATUS, 8'h10);
            st(0, 0, 0);
        end
        chk(nstart, 0);
        wb(1'b1, fcs_pkg::OFS_DIVIDER, 8'h13);
        for (int i = 0; i < 5; i++) begin
            erased <= 1'b1;
            slow <= i[0];
            go(codes[i], 16'hffb0 + 16'(i));
            idle();
            es++;
            b = (codes[i] == fcs_pkg::CMD_BLANK) ? 1 : 0;
            st(0, 0, b);
            chk(32'(last_cmd), 32'(codes[i]));
            chk(nstart, es);
            chk(nsec, 1);
        end
        c = 8'($urandom);
        if (c inside {codes})
            c = 8'h7f;
        go(c, 16'hffb0);
        idle();
        st(1, 0, 0);
        chk(nstart, es);
        wb(1'b1, fcs_pkg::OFS_STATUS, 8'h10);
        wb(1'b1, fcs_pkg::OFS_CONFIG, 8'h20);
        go(fcs_pkg::CMD_BYTE_PROG, 16'hffb3);
        idle();
        chk(32'(last_key), 32'({3'd3, kd}));
        chk(nstart, es);
        wb(1'b1, fcs_pkg::OFS_CONFIG, 8'h00);
        wb(1'b1, fcs_pkg::OFS_STATUS, 8'h10);
        dbg(8'h00);
        // mass erase with protection enabled is refused and sets the violation flag
        go(fcs_pkg::CMD_MASS_ERASE, 16'h0000);
        idle();
        st(0, 1, 0);
        chk(nstart, es);
        wb(1'b1, fcs_pkg::OFS_STATUS, 8'h20);
        st(0, 0, 0);
        dbg(8'h01);
        slow <= 1'b1;
        go(fcs_pkg::CMD_PAGE_ERASE, 16'h0200);
        stop <= 1'b1;
        idle();
        stop <= 1'b0;
        st(1, 0, 0);
        end_of_test();
    end
endmodule
